//--- logic/fbst_pkg.sv
package fbst_pkg;

	// ----------------------------------------------------------------
	// register lengths
	// ----------------------------------------------------------------
	localparam int IR_LEN = 4;
	localparam int ID_LEN = 32;

	// ----------------------------------------------------------------
	// instruction codes and capture values
	// ----------------------------------------------------------------
	localparam logic [IR_LEN-1:0] IR_BYPASS = 4'hF;
	localparam logic [IR_LEN-1:0] IR_IDCODE = 4'h2;
	localparam logic [IR_LEN-1:0] IR_CAPTURE = 4'h1;
	localparam logic [IR_LEN-1:0] IR_RESET = IR_IDCODE;

	// identification word: arbitrary value, bit 0 must stay one
	localparam logic [ID_LEN-1:0] ID_DEFAULT = 32'h0000_0001;
	localparam logic [ID_LEN-1:0] ID_CLEAR = 32'h0000_0000;

	// ----------------------------------------------------------------
	// crossing
	// ----------------------------------------------------------------
	localparam int SYNC_STAGES = 3;

	// ----------------------------------------------------------------
	// controller states
	// ----------------------------------------------------------------
	typedef enum logic [3:0]
	{
		ST_RESET,
		ST_IDLE,
		ST_SEL_DR,
		ST_CAP_DR,
		ST_SHIFT_DR,
		ST_EXIT1_DR,
		ST_PAUSE_DR,
		ST_EXIT2_DR,
		ST_UPD_DR,
		ST_SEL_IR,
		ST_CAP_IR,
		ST_SHIFT_IR,
		ST_EXIT1_IR,
		ST_PAUSE_IR,
		ST_EXIT2_IR,
		ST_UPD_IR
	} fbst_state_t;

endpackage

//--- logic/fbst_tap_fsm.sv
`timescale 1ns/10ps
module fbst_tap_fsm
(
	input wire logic tck,
	input wire logic tapRst_b,
	input wire logic tms,
	output fbst_pkg::fbst_state_t state_q
);

	fbst_pkg::fbst_state_t state_d;

	// ----------------------------------------------------------------
	// sixteen-state sequence steered by tms
	// ----------------------------------------------------------------
	always_comb
	begin
		case (state_q)
			fbst_pkg::ST_RESET: state_d = tms ? fbst_pkg::ST_RESET : fbst_pkg::ST_IDLE;
			fbst_pkg::ST_IDLE: state_d = tms ? fbst_pkg::ST_SEL_DR : fbst_pkg::ST_IDLE;
			fbst_pkg::ST_SEL_DR: state_d = tms ? fbst_pkg::ST_SEL_IR : fbst_pkg::ST_CAP_DR;
			fbst_pkg::ST_CAP_DR: state_d = tms ? fbst_pkg::ST_EXIT1_DR : fbst_pkg::ST_SHIFT_DR;
			fbst_pkg::ST_SHIFT_DR: state_d = tms ? fbst_pkg::ST_EXIT1_DR : fbst_pkg::ST_SHIFT_DR;
			fbst_pkg::ST_EXIT1_DR: state_d = tms ? fbst_pkg::ST_UPD_DR : fbst_pkg::ST_PAUSE_DR;
			fbst_pkg::ST_PAUSE_DR: state_d = tms ? fbst_pkg::ST_EXIT2_DR : fbst_pkg::ST_PAUSE_DR;
			fbst_pkg::ST_EXIT2_DR: state_d = tms ? fbst_pkg::ST_UPD_DR : fbst_pkg::ST_SHIFT_DR;
			fbst_pkg::ST_UPD_DR: state_d = tms ? fbst_pkg::ST_SEL_DR : fbst_pkg::ST_IDLE;
			fbst_pkg::ST_SEL_IR: state_d = tms ? fbst_pkg::ST_RESET : fbst_pkg::ST_CAP_IR;
			fbst_pkg::ST_CAP_IR: state_d = tms ? fbst_pkg::ST_EXIT1_IR : fbst_pkg::ST_SHIFT_IR;
			fbst_pkg::ST_SHIFT_IR: state_d = tms ? fbst_pkg::ST_EXIT1_IR : fbst_pkg::ST_SHIFT_IR;
			fbst_pkg::ST_EXIT1_IR: state_d = tms ? fbst_pkg::ST_UPD_IR : fbst_pkg::ST_PAUSE_IR;
			fbst_pkg::ST_PAUSE_IR: state_d = tms ? fbst_pkg::ST_EXIT2_IR : fbst_pkg::ST_PAUSE_IR;
			fbst_pkg::ST_EXIT2_IR: state_d = tms ? fbst_pkg::ST_UPD_IR : fbst_pkg::ST_SHIFT_IR;
			fbst_pkg::ST_UPD_IR: state_d = tms ? fbst_pkg::ST_SEL_DR : fbst_pkg::ST_IDLE;
			default: state_d = fbst_pkg::ST_RESET;
		endcase
	end

	// ----------------------------------------------------------------
	// state register, cleared without waiting for tck
	// ----------------------------------------------------------------
	always_ff @(posedge tck or negedge tapRst_b)
	begin
		if (!tapRst_b)
			state_q <= fbst_pkg::ST_RESET;
		else
			state_q <= state_d;
	end

endmodule

//--- logic/fbst_tap.sv
`timescale 1ns/10ps
module fbst_tap
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic tck,
	input wire logic trst_b,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdoOe,
	output logic tapInReset,
	output logic idSelected
);

	// ----------------------------------------------------------------
	// power-up release, system domain
	// ----------------------------------------------------------------
	logic porDone_q;
	logic tapRst_b;

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			porDone_q <= 1'b0;
		else
			porDone_q <= 1'b1;
	end

	// controller held in reset until the system reset has been seen
	assign tapRst_b = trst_b & porDone_q;

	// ----------------------------------------------------------------
	// controller
	// ----------------------------------------------------------------
	fbst_pkg::fbst_state_t state_q;

	fbst_tap_fsm fbst_tap_fsm_i
	(
		.tck(tck),
		.tapRst_b(tapRst_b),
		.tms(tms),
		.state_q(state_q)
	);

	// ----------------------------------------------------------------
	// state decode
	// ----------------------------------------------------------------
	wire inReset = (state_q == fbst_pkg::ST_RESET);
	wire capIr = (state_q == fbst_pkg::ST_CAP_IR);
	wire shiftIr = (state_q == fbst_pkg::ST_SHIFT_IR);
	wire updIr = (state_q == fbst_pkg::ST_UPD_IR);
	wire capDr = (state_q == fbst_pkg::ST_CAP_DR);
	wire shiftDr = (state_q == fbst_pkg::ST_SHIFT_DR);

	// ----------------------------------------------------------------
	// instruction register
	// ----------------------------------------------------------------
	logic [fbst_pkg::IR_LEN-1:0] irShift_q;
	logic [fbst_pkg::IR_LEN-1:0] irShift_d;
	logic [fbst_pkg::IR_LEN-1:0] ir_q;
	logic [fbst_pkg::IR_LEN-1:0] ir_d;

	// tdi has no pull-up in this block, so an open tdi shifts in z
	wire serialIn = tdi;

	assign irShift_d = capIr ? fbst_pkg::IR_CAPTURE :
		shiftIr ? {serialIn, irShift_q[fbst_pkg::IR_LEN-1:1]} : irShift_q;
	assign ir_d = inReset ? fbst_pkg::IR_RESET : updIr ? irShift_q : ir_q;

	always_ff @(posedge tck or negedge tapRst_b)
	begin
		if (!tapRst_b)
		begin
			irShift_q <= fbst_pkg::IR_CAPTURE;
			ir_q <= fbst_pkg::IR_RESET;
		end
		else
		begin
			irShift_q <= irShift_d;
			ir_q <= ir_d;
		end
	end

	// ----------------------------------------------------------------
	// data registers; unknown codes select bypass
	// ----------------------------------------------------------------
	logic [fbst_pkg::ID_LEN-1:0] idShift_q;
	logic [fbst_pkg::ID_LEN-1:0] idShift_d;
	logic bypass_q;
	logic bypass_d;

	wire idSel = (ir_q == fbst_pkg::IR_IDCODE);

	assign idShift_d = (capDr && idSel) ? fbst_pkg::ID_DEFAULT :
		(shiftDr && idSel) ? {serialIn, idShift_q[fbst_pkg::ID_LEN-1:1]} : idShift_q;
	assign bypass_d = capDr ? 1'b0 : (shiftDr && !idSel) ? serialIn : bypass_q;

	always_ff @(posedge tck or negedge tapRst_b)
	begin
		if (!tapRst_b)
		begin
			idShift_q <= fbst_pkg::ID_CLEAR;
			bypass_q <= 1'b0;
		end
		else
		begin
			idShift_q <= idShift_d;
			bypass_q <= bypass_d;
		end
	end

	// ----------------------------------------------------------------
	// serial output on falling tck
	// ----------------------------------------------------------------
	logic tdo_d;
	logic tdoOe_d;

	assign tdo_d = shiftIr ? irShift_q[0] : idSel ? idShift_q[0] : bypass_q;
	assign tdoOe_d = shiftIr | shiftDr;

	always_ff @(negedge tck or negedge tapRst_b)
	begin
		if (!tapRst_b)
		begin
			tdo <= 1'b0;
			tdoOe <= 1'b0;
		end
		else
		begin
			tdo <= tdo_d;
			tdoOe <= tdoOe_d;
		end
	end

	// ----------------------------------------------------------------
	// status levels registered in tck domain
	// ----------------------------------------------------------------
	logic inResetLvl_q;
	logic idSelLvl_q;

	always_ff @(posedge tck or negedge tapRst_b)
	begin
		if (!tapRst_b)
		begin
			inResetLvl_q <= 1'b1;
			idSelLvl_q <= 1'b1;
		end
		else
		begin
			inResetLvl_q <= inReset;
			idSelLvl_q <= idSel;
		end
	end

	// ----------------------------------------------------------------
	// crossing into clk domain: three stages, act once 2nd and 3rd agree
	// ----------------------------------------------------------------
	function automatic logic agreeNext(input logic cur, input logic s2, input logic s3);
		agreeNext = (s2 == s3) ? s3 : cur;
	endfunction

	logic [fbst_pkg::SYNC_STAGES-1:0] rstSync_q;
	logic [fbst_pkg::SYNC_STAGES-1:0] idSync_q;

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			rstSync_q <= '1;
			idSync_q <= '1;
		end
		else
		begin
			rstSync_q <= {rstSync_q[1:0], inResetLvl_q};
			idSync_q <= {idSync_q[1:0], idSelLvl_q};
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			tapInReset <= 1'b1;
			idSelected <= 1'b1;
		end
		else
		begin
			tapInReset <= agreeNext(tapInReset, rstSync_q[1], rstSync_q[2]);
			idSelected <= agreeNext(idSelected, idSync_q[1], idSync_q[2]);
		end
	end

endmodule

//--- dv/fbst_monitor.sv
`timescale 1ns/10ps
module fbst_monitor
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic tck,
	input wire logic trst_b,
	input wire logic tms,
	input wire logic tdi,
	input wire logic tdo,
	input wire logic tdoOe,
	input wire logic tapInReset,
	input wire logic idSelected
);
	a_high_stable: assert property (@(posedge clk) disable iff (!trst_b || !rst_b)
		tck && $past(tck) |-> $stable(tdo) && $stable(tdoOe)) else $error("tdo moved, tck high");
	a_oe_edge: assert property (@(posedge clk) disable iff (!trst_b || !rst_b)
		$changed(tdoOe) |-> !tck) else $error("tdoOe moved on rising tck");
	a_trst_clear: assert property (@(posedge clk) disable iff (!rst_b)
		!trst_b |-> !tdoOe && !tdo) else $error("tdo driven under trst_b");
	a_por_status: assert property (@(posedge clk)
		!rst_b |=> tapInReset && idSelected) else $error("rst_b did not reset port");
	a_trst_status: assert property (@(posedge clk) disable iff (!rst_b)
		$fell(trst_b) |-> ##[1:6] tapInReset && idSelected) else $error("trst_b status late");
	a_reset_quiet: assert property (@(posedge clk) disable iff (!rst_b)
		tapInReset |-> !tdoOe) else $error("tdo driven in reset");
	a_five_ones: assert property (@(posedge tck) disable iff (!trst_b || !rst_b)
		tms [*5] |=> !tdoOe) else $error("five tms ones missed reset");
	a_shift_hold: assert property (@(posedge tck) disable iff (!trst_b || !rst_b)
		tdoOe |=> tdoOe == !$past(tms)) else $error("shift state wrong");
endmodule

bind fbst_tap fbst_monitor fbst_monitor_i (.clk, .rst_b, .tck, .trst_b, .tms, .tdi, .tdo, .tdoOe,
	.tapInReset, .idSelected);

//--- dv/fbst_ctl.sv
`timescale 1ns/10ps
module fbst_ctl
(
	output logic tck,
	output logic trst_b,
	output wire logic tms,
	output logic tdi,
	input wire logic tdo
);
	logic tmsV;
	logic tmsOe;
	// floated tms reads as one through the bench pull-up
	assign tms = tmsOe ? tmsV : 1'hz;
	initial
	begin
		tck = 1'h0;
		trst_b = 1'h0;
		tmsV = 1'h1;
		tmsOe = 1'h1;
		tdi = 1'h1;
	end
	// inputs change with tck low, tdo taken at the rising edge
	task step(input logic m, input logic d, output logic o);
		tmsV = m;
		tdi = d;
		#40 tck = 1'h1;
		o = tdo;
		#40 tck = 1'h0;
	endtask
	task walk(input logic [7:0] m, input int n);
		logic o;
		for (int i = 0; i < n; i++)
			step(m[i], 1'h0, o);
	endtask
	// from idle: header, n bits lsb first, back to idle
	task scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
		dout = 32'h0;
		walk(ir ? 8'h3 : 8'h1, ir ? 4 : 3);
		for (int i = 0; i < n; i++)
			step(i == n - 1, din[i], dout[i]);
		walk(8'h1, 2);
	endtask
endmodule

//--- dv/fbst_tap_tb.sv
`timescale 1ns/10ps
module fbst_tap_tb;
	logic clk;
	logic rst_b;
	wire tck;
	wire trst_b;
	wire tms;
	wire tdi;
	wire tdoW;
	logic tdo;
	logic tdoOe;
	logic tapInReset;
	logic idSelected;
	logic [31:0] got;
	int err_total;
	int samples_checked;
	pullup (tms);
	assign tdoW = tdoOe ? tdo : 1'hz;
	fbst_tap fbst_tap_i (.clk, .rst_b, .tck, .trst_b, .tms, .tdi, .tdo, .tdoOe, .tapInReset,
		.idSelected);
	fbst_ctl fbst_ctl_i (.tck, .trst_b, .tms, .tdi, .tdo(tdoW));
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task stop_test;
		if (err_total == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task t_idcode;
		#3 fbst_ctl_i.trst_b = 1'h1;
		fbst_ctl_i.walk(8'h0, 1);
		#1 chk("oeIdle", 1'h0, tdoOe);
		fbst_ctl_i.scan(1'h0, 32, 32'h0, got);
		chk("idWord", fbst_pkg::ID_DEFAULT, got);
	endtask
	task t_bypass;
		fbst_ctl_i.scan(1'h1, 4, {28'h0, fbst_pkg::IR_BYPASS}, got);
		chk("irCapture", fbst_pkg::IR_CAPTURE, got);
		fbst_ctl_i.scan(1'h0, 3, 32'h6, got);
		chk("bypass", 32'h4, got);
		repeat (16) @(posedge clk);
		chk("idSel", 1'h0, idSelected);
	endtask
	task t_por;
		rst_b <= 1'h0;
		repeat (4) @(posedge clk);
		rst_b <= 1'h1;
		repeat (2) @(posedge clk);
		chk("porReset", 1'h1, tapInReset);
		#3 fbst_ctl_i.walk(8'h0, 1);
		fbst_ctl_i.scan(1'h0, 32, 32'h0, got);
		chk("porId", fbst_pkg::ID_DEFAULT, got);
	endtask
	task t_five;
		#3 fbst_ctl_i.tmsOe = 1'h0;
		fbst_ctl_i.walk(8'h0, 5);
		fbst_ctl_i.tmsOe = 1'h1;
		repeat (16) @(posedge clk);
		chk("fiveOnes", 1'h1, tapInReset);
		chk("idAfter", 1'h1, idSelected);
	endtask
	task t_trst;
		#3 fbst_ctl_i.walk(8'h2, 4);
		#1 chk("oeShift", 1'h1, tdoOe);
		fbst_ctl_i.trst_b = 1'h0;
		#1 chk("oeTrst", 1'h0, tdoOe);
		repeat (16) @(posedge clk);
		chk("trstReset", 1'h1, tapInReset);
		#3 fbst_ctl_i.trst_b = 1'h1;
	endtask
	initial
	begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		#40000;
		err_total++;
		stop_test();
	end
	initial
	begin
		err_total = 0;
		samples_checked = 0;
		rst_b = 1'h0;
		repeat (4) @(posedge clk);
		rst_b <= 1'h1;
		repeat (2) @(posedge clk);
		t_idcode();
		t_bypass();
		t_por();
		t_bypass();
		t_five();
		t_trst();
		stop_test();
	end
endmodule
